/* File: hdl/csf_flags.sv */
// Processor status-flag register with register port and event interrupt
module csf_flags
    import csf_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // ALU and instruction unit
    input  wire csf_alu_t    alu,
    input  wire logic        alu_valid,
    input  wire csf_sys_t    sys,
    // Register port
    input  wire logic [1:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Flags and interrupt
    output logic      [7:0]  flags,
    output logic             irq
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] flags_ff;      // Bit layout of the flag register
    logic [7:0] nxt_flags;
    logic [7:0] rdata_ff;
    logic [2:0] stat_ff;
    logic [2:0] mask_ff;

    // ------------------------------------------------------------
    // Arithmetic flag next values
    // ------------------------------------------------------------
    wire        wr_flags = reg_wr && (reg_addr == OFS_FLAGS);
    wire        upd_any  = alu_valid;
    wire        new_ovf  = alu.carry_in7 ^ alu.carry_out;
    wire        ovf_now  = (upd_any && alu.upd.ovf) ? new_ovf : flags_ff[BIT_OVF];
    wire        new_c    = alu.is_rotate ? alu.rot_carry : alu.carry_out;
    wire        new_z    = (alu.result == 8'h00);
    wire        new_sc   = ovf_now ^ alu.result[7];

    // Power-down and timeout next values; only these events touch them
    wire        nxt_pd   = sys.sleep ? 1'b1 : (sys.watchdog_clear_instruction ? 1'b0 : flags_ff[BIT_PDOWN]);
    wire        nxt_to   = sys.wdt_timeout ? 1'b1
                         : ((sys.watchdog_clear_instruction || sys.sleep) ? 1'b0 : flags_ff[BIT_WDTO]);

    // Flag merge: instruction result wins over a software write in the same cycle
    always_comb
    begin
        nxt_flags = flags_ff;
        if (wr_flags)
        begin
            nxt_flags[BIT_CARRY] = reg_wdata[BIT_CARRY];
            nxt_flags[BIT_HALF]  = reg_wdata[BIT_HALF];
            nxt_flags[BIT_ZERO]  = reg_wdata[BIT_ZERO];
            nxt_flags[BIT_OVF]   = reg_wdata[BIT_OVF];
            nxt_flags[BIT_CZERO] = reg_wdata[BIT_CZERO];
            nxt_flags[BIT_SIGN]  = reg_wdata[BIT_SIGN];
        end
        if (upd_any)
        begin
            if (alu.upd.carry) nxt_flags[BIT_CARRY] = new_c;
            if (alu.upd.half)  nxt_flags[BIT_HALF]  = alu.half_out;
            if (alu.upd.zero)  nxt_flags[BIT_ZERO]  = new_z;
            if (alu.upd.ovf)   nxt_flags[BIT_OVF]   = new_ovf;
            if (alu.upd.sign)  nxt_flags[BIT_SIGN]  = new_sc;
            if (alu.upd.czero) nxt_flags[BIT_CZERO] = alu.czero_val;
        end
        nxt_flags[BIT_PDOWN] = nxt_pd;
        nxt_flags[BIT_WDTO]  = nxt_to;
    end

    // Flag register; system bits zero at power-on
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            flags_ff <= RST_FLAGS;
        else
            flags_ff <= nxt_flags;
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    wire [2:0] ev       = {sys.watchdog_clear_instruction, sys.sleep, sys.wdt_timeout};
    wire [2:0] w1c      = (reg_wr && reg_addr == OFS_IRQ_STAT) ? reg_wdata[2:0] : 3'h0;
    wire [2:0] nxt_stat = (stat_ff & ~w1c) | ev;                                // Set wins over clear

    // Status and mask registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stat_ff <= RST_IRQ;
            mask_ff <= RST_IRQ;
        end
        else
        begin
            stat_ff <= nxt_stat;
            if (reg_wr && reg_addr == OFS_IRQ_MASK)
                mask_ff <= reg_wdata[2:0];
        end
    end

    assign irq = |(stat_ff & mask_ff);

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    wire [7:0] rd_mux = (reg_addr == OFS_FLAGS)    ? flags_ff
                      : (reg_addr == OFS_IRQ_STAT) ? {5'h00, stat_ff}
                      : (reg_addr == OFS_IRQ_MASK) ? {5'h00, mask_ff}
                      : 8'h00;

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_ff <= 8'h00;
        else
            rdata_ff <= reg_rd ? rd_mux : 8'h00;
    end

    assign reg_rdata = rdata_ff;
    assign flags     = flags_ff;   // No push path exists; software saves flags

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_sys_write_ignored: assert property (wr_flags && !sys.sleep && !sys.watchdog_clear_instruction && !sys.wdt_timeout
        |=> flags[5:4] == $past(flags[5:4])) else $error("write changed system bits");
    a_pd_on_sleep: assert property (sys.sleep |=> flags[BIT_PDOWN])
        else $error("power down not set");
    a_pd_watchdog_clear_instruction: assert property (sys.watchdog_clear_instruction && !sys.sleep |=> !flags[BIT_PDOWN])
        else $error("power down not cleared");
    a_to_timeout_set: assert property (sys.wdt_timeout |=> flags[BIT_WDTO])
        else $error("timeout not set");
    a_to_clear_evt: assert property (!sys.wdt_timeout && (sys.watchdog_clear_instruction || sys.sleep) |=> !flags[BIT_WDTO])
        else $error("timeout not cleared");
    a_carry_update: assert property (alu_valid && alu.upd.carry |=> flags[BIT_CARRY] == $past(new_c))
        else $error("carry wrong");
    a_zero_update: assert property (alu_valid && alu.upd.zero |=> flags[BIT_ZERO] == ($past(alu.result) == 8'h00))
        else $error("zero wrong");
    a_ovf_sign_tie: assert property (alu_valid && alu.upd.ovf && alu.upd.sign
        |=> flags[BIT_SIGN] == (flags[BIT_OVF] ^ $past(alu.result[7]))) else $error("sign wrong");
    a_half_update: assert property (alu_valid && alu.upd.half |=> flags[BIT_HALF] == $past(alu.half_out))
        else $error("half carry wrong");
    a_read_one_cycle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside slot");

    // ------------------------------------------------------------
    // Arithmetic flags hold when their update bit is clear
    // ------------------------------------------------------------
    // Carry keeps its value without update or write
    a_carry_hold: assert property (alu_valid && !alu.upd.carry && !wr_flags
        |=> flags[BIT_CARRY] == $past(flags[BIT_CARRY])) else $error("carry changed without update");

    // Half carry keeps its value without update or write
    a_half_hold: assert property (alu_valid && !alu.upd.half && !wr_flags
        |=> flags[BIT_HALF] == $past(flags[BIT_HALF])) else $error("half carry changed without update");

    // Zero keeps its value without update or write
    a_zero_hold: assert property (alu_valid && !alu.upd.zero && !wr_flags
        |=> flags[BIT_ZERO] == $past(flags[BIT_ZERO])) else $error("zero changed without update");

    // ------------------------------------------------------------
    // Arithmetic flag values
    // ------------------------------------------------------------
    // Overflow is carry into the top bit against carry out of it
    a_ovf_update: assert property (alu_valid && alu.upd.ovf
        |=> flags[BIT_OVF] == $past(alu.carry_in7 ^ alu.carry_out)) else $error("overflow wrong");

    // Sign combined uses the held overflow when overflow is not updated
    a_sign_held_ovf: assert property (alu_valid && alu.upd.sign && !alu.upd.ovf
        |=> flags[BIT_SIGN] == ($past(flags[BIT_OVF]) ^ $past(alu.result[7]))) else $error("sign wrong");

    // Rotate through carry loads the rotated bit
    a_rotate_carry: assert property (alu_valid && alu.upd.carry && alu.is_rotate
        |=> flags[BIT_CARRY] == $past(alu.rot_carry)) else $error("rotate carry wrong");

    // Chained zero takes the value formed outside
    a_czero_update: assert property (alu_valid && alu.upd.czero
        |=> flags[BIT_CZERO] == $past(alu.czero_val)) else $error("chained zero wrong");

    // ------------------------------------------------------------
    // Software writes to the writable bits
    // ------------------------------------------------------------
    // Carry follows a write when no instruction updates it
    a_write_carry: assert property (wr_flags && !(alu_valid && alu.upd.carry)
        |=> flags[BIT_CARRY] == $past(reg_wdata[BIT_CARRY])) else $error("carry write lost");

    // Half carry follows a write when no instruction updates it
    a_write_half: assert property (wr_flags && !(alu_valid && alu.upd.half)
        |=> flags[BIT_HALF] == $past(reg_wdata[BIT_HALF])) else $error("half carry write lost");

    // Zero follows a write when no instruction updates it
    a_write_zero: assert property (wr_flags && !(alu_valid && alu.upd.zero)
        |=> flags[BIT_ZERO] == $past(reg_wdata[BIT_ZERO])) else $error("zero write lost");

    // Overflow follows a write when no instruction updates it
    a_write_ovf: assert property (wr_flags && !(alu_valid && alu.upd.ovf)
        |=> flags[BIT_OVF] == $past(reg_wdata[BIT_OVF])) else $error("overflow write lost");

    // Sign combined follows a write when no instruction updates it
    a_write_sign: assert property (wr_flags && !(alu_valid && alu.upd.sign)
        |=> flags[BIT_SIGN] == $past(reg_wdata[BIT_SIGN])) else $error("sign write lost");

    // Chained zero follows a write when no instruction updates it
    a_write_czero: assert property (wr_flags && !(alu_valid && alu.upd.czero)
        |=> flags[BIT_CZERO] == $past(reg_wdata[BIT_CZERO])) else $error("chained zero write lost");

    // ------------------------------------------------------------
    // System bits change only on their own events
    // ------------------------------------------------------------
    // Power down is still without sleep or watchdog clear
    a_pd_quiet: assert property (!sys.sleep && !sys.watchdog_clear_instruction
        |=> flags[BIT_PDOWN] == $past(flags[BIT_PDOWN])) else $error("power down moved");

    // Timeout is still without its three events
    a_to_quiet: assert property (!sys.wdt_timeout && !sys.watchdog_clear_instruction && !sys.sleep
        |=> flags[BIT_WDTO] == $past(flags[BIT_WDTO])) else $error("timeout moved");

    // ------------------------------------------------------------
    // Interrupt status: sticky, set wins over write-one-clear
    // ------------------------------------------------------------
    // Timeout sets its status bit
    a_stat_wdto_set: assert property (sys.wdt_timeout |=> stat_ff[EV_WDTO])
        else $error("timeout status not set");

    // Sleep sets its status bit
    a_stat_sleep_set: assert property (sys.sleep |=> stat_ff[EV_SLEEP])
        else $error("sleep status not set");

    // Watchdog clear sets its status bit
    a_stat_clr_set: assert property (sys.watchdog_clear_instruction |=> stat_ff[EV_CLRWD])
        else $error("clear status not set");

    // Writing a one clears the timeout status bit
    a_stat_wdto_w1c: assert property (reg_wr && reg_addr == OFS_IRQ_STAT && reg_wdata[EV_WDTO] && !sys.wdt_timeout
        |=> !stat_ff[EV_WDTO]) else $error("timeout status not cleared");

    // Writing a one clears the sleep status bit
    a_stat_sleep_w1c: assert property (reg_wr && reg_addr == OFS_IRQ_STAT && reg_wdata[EV_SLEEP] && !sys.sleep
        |=> !stat_ff[EV_SLEEP]) else $error("sleep status not cleared");

    // Writing a one clears the watchdog clear status bit
    a_stat_clr_w1c: assert property (reg_wr && reg_addr == OFS_IRQ_STAT && reg_wdata[EV_CLRWD] && !sys.watchdog_clear_instruction
        |=> !stat_ff[EV_CLRWD]) else $error("clear status not cleared");

    // A set sleep status bit stays without a clearing write
    a_stat_sleep_sticky: assert property (stat_ff[EV_SLEEP] && !(reg_wr && reg_addr == OFS_IRQ_STAT)
        |=> stat_ff[EV_SLEEP]) else $error("sleep status lost");

    // A set timeout status bit stays without a clearing write
    a_stat_wdto_sticky: assert property (stat_ff[EV_WDTO] && !(reg_wr && reg_addr == OFS_IRQ_STAT)
        |=> stat_ff[EV_WDTO]) else $error("timeout status lost");

    // Mask register takes the written value
    a_mask_write: assert property (reg_wr && reg_addr == OFS_IRQ_MASK
        |=> mask_ff == $past(reg_wdata[2:0])) else $error("mask write lost");

    // ------------------------------------------------------------
    // Read port contents
    // ------------------------------------------------------------
    // Flag read returns the flag register of the strobe cycle
    a_read_flags: assert property (reg_rd && reg_addr == OFS_FLAGS
        |=> reg_rdata == $past(flags)) else $error("flag read wrong");

    // Status read returns the status bits
    a_read_stat: assert property (reg_rd && reg_addr == OFS_IRQ_STAT
        |=> reg_rdata == {5'h00, $past(stat_ff)}) else $error("status read wrong");

    // Mask read returns the mask bits
    a_read_mask: assert property (reg_rd && reg_addr == OFS_IRQ_MASK
        |=> reg_rdata == {5'h00, $past(mask_ff)}) else $error("mask read wrong");

    // Unmapped index reads zero
    a_read_unmapped: assert property (reg_rd && reg_addr == 2'h3
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");

    // ------------------------------------------------------------
    // Scenario cover
    // ------------------------------------------------------------
    c_sleep_then_clr: cover property (sys.sleep ##[1:20] sys.watchdog_clear_instruction);
    c_timeout_irq: cover property (sys.wdt_timeout ##1 irq);
    c_write_and_alu: cover property (wr_flags && alu_valid);
    c_rotate_carry: cover property (alu_valid && alu.is_rotate);

endmodule : csf_flags

/* File: hdl/csf_pkg.sv */
// Package for the processor status-flag register: bit positions, reset values and carriers
// ----------------------------------------------------------------
// Summary of operation
// - One 8-bit flag register: bit 7 sign combined, 6 chained zero, 5 watchdog timeout, 4 power down, 3 overflow, 2 zero, 1 half carry, 0 carry.
// - Arithmetic and logical instructions may change every flag except the watchdog timeout and power down bits, which are read-only to writes.
// - A software write never changes the watchdog timeout or power down bits, whatever value is written.
// - Carry is set on carry out in addition or no borrow in subtraction, cleared otherwise, and rotates through carry update it.
// - Half carry is set on a carry out of the low nibble in addition or no borrow into the low nibble in subtraction.
// - Zero is set when an arithmetic or logical result is zero, cleared otherwise.
// - Overflow is set when the carry into the top result bit differs from the carry out of it.
// - Sign combined is the exclusive-OR of overflow and the top bit of the current result.
// - Power down is cleared at power-up and by the watchdog clear instruction, set by the sleep instruction, and nothing else.
// - Watchdog timeout is cleared at power-up, by watchdog clear and by sleep, set by a watchdog time-out, and nothing else.
// - Interrupt entry and subroutine calls do not save the flag register; software saves it when needed.
// ----------------------------------------------------------------
package csf_pkg;

    // ------------------------------------------------------------
    // Bit positions of the flag register
    // ------------------------------------------------------------
    localparam int BIT_CARRY = 0;
    localparam int BIT_HALF  = 1;
    localparam int BIT_ZERO  = 2;
    localparam int BIT_OVF   = 3;
    localparam int BIT_PDOWN = 4;
    localparam int BIT_WDTO  = 5;
    localparam int BIT_CZERO = 6;
    localparam int BIT_SIGN  = 7;

    // ------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] OFS_FLAGS    = 2'h0;
    localparam logic [1:0] OFS_IRQ_STAT = 2'h1;
    localparam logic [1:0] OFS_IRQ_MASK = 2'h2;
    localparam logic [7:0] RST_FLAGS    = 8'h00;
    localparam logic [2:0] RST_IRQ      = 3'h0;

    // Interrupt event bit positions
    localparam int EV_WDTO  = 0;
    localparam int EV_SLEEP = 1;
    localparam int EV_CLRWD = 2;

    // Which arithmetic flags an instruction updates
    typedef struct packed {
        logic carry;
        logic half;
        logic zero;
        logic ovf;
        logic sign;
        logic czero;
    } csf_upd_t;

    // ALU result report for one instruction
    typedef struct packed {
        csf_upd_t    upd;
        logic [7:0]  result;
        logic        carry_out;
        logic        carry_in7;
        logic        half_out;
        logic        czero_val;
        logic        rot_carry;
        logic        is_rotate;
    } csf_alu_t;

    // System events from the instruction unit and watchdog
    typedef struct packed {
        logic wdt_timeout;
        logic watchdog_clear_instruction;
        logic sleep;
    } csf_sys_t;

endpackage : csf_pkg

/* File: tb/csf_alu_model.sv */
// Behavioural ALU that reports one add or subtract to the flag register
module csf_alu_model
    import csf_pkg::*;
(
    // Operation request
    input  wire logic       go,
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       sub,
    // Report
    output csf_alu_t        alu,
    output logic            alu_valid
);
    // Subtract adds the inverted operand plus one, so carry means no borrow
    wire logic [7:0] opb = sub ? ~b : b;
    wire logic [8:0] sum = {1'b0, a} + {1'b0, opb} + {8'h00, sub};
    wire logic [4:0] low = {1'b0, a[3:0]} + {1'b0, opb[3:0]} + {4'h0, sub};
    wire logic [7:0] top = {1'b0, a[6:0]} + {1'b0, opb[6:0]} + {7'h00, sub};
    // Report fields, every arithmetic flag updated
    assign alu.upd       = '1;
    assign alu.result    = sum[7:0];
    assign alu.carry_out = sum[8];
    assign alu.carry_in7 = top[7];
    assign alu.half_out  = low[4];
    assign alu.czero_val = 1'b0;
    assign alu.rot_carry = 1'b0;
    assign alu.is_rotate = 1'b0;
    assign alu_valid     = go;
endmodule : csf_alu_model

/* File: tb/tb.sv */
// Self-checking bench for the processor status-flag register
module tb
    import csf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 1'b0, reset_n = 1'b0, go = 1'b0, sub = 1'b0, irq;
    logic [7:0] a = 8'h00, b = 8'h00, reg_wdata = 8'h00, reg_rdata, flags, rd;
    logic [1:0] reg_addr = 2'h0;
    logic       reg_wr = 1'b0, reg_rd = 1'b0, alu_valid;
    csf_sys_t   sys = '0;
    csf_alu_t   alu;
    int         n_mismatch = 0, checks_done = 0;
    // Clock and watchdog
    always #50 clk = ~clk;
    initial
    begin
        #200us;
        n_mismatch++;
        stop_test();
    end
    csf_flags i_csf_flags (.clk(clk), .reset_n(reset_n), .alu(alu), .alu_valid(alu_valid), .sys(sys),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .flags(flags), .irq(irq));
    csf_alu_model i_csf_alu_model (.go(go), .a(a), .b(b), .sub(sub), .alu(alu), .alu_valid(alu_valid));
    // Compare and verdict
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task stop_test;
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    // Bus cycles and event pulses
    task wr(input logic [1:0] ad, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= ad; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task rdr(input logic [1:0] ad);
        @(posedge clk);
        reg_addr <= ad; reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask : rdr
    task ev(input csf_sys_t v);
        @(posedge clk);
        sys <= v;
        @(posedge clk);
        sys <= '0;
        #1;
    endtask : ev
    // Scenarios
    task t_system;
        ev(3'b001); chk(flags, 8'h10);
        ev(3'b100); chk(flags, 8'h30);
        ev(3'b001); chk(flags, 8'h10);
        ev(3'b110); chk(flags, 8'h20);
        ev(3'b010); chk(flags, 8'h00);
    endtask : t_system
    task t_irq;
        chk({7'h00, irq}, 8'h00);
        wr(OFS_IRQ_MASK, 8'h02); chk({7'h00, irq}, 8'h01);
        rdr(OFS_IRQ_STAT); chk(rd, 8'h07);
        wr(OFS_IRQ_STAT, 8'h02); chk({7'h00, irq}, 8'h00);
        rdr(OFS_IRQ_STAT); chk(rd, 8'h05);
    endtask : t_irq
    task t_alu;
        logic [7:0] ta [5] = '{8'h0F, 8'hFF, 8'h7F, 8'h05, 8'h80};
        logic [7:0] tb_ [5] = '{8'h01, 8'h01, 8'h01, 8'h05, 8'h01};
        logic [7:0] te [5] = '{8'h02, 8'h07, 8'h0A, 8'h07, 8'h89};
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            go <= 1'b1; a <= ta[i]; b <= tb_[i]; sub <= (i > 2);
            @(posedge clk);
            go <= 1'b0;
            #1 chk(flags, te[i]);
        end
    endtask : t_alu
    task t_write;
        ev(3'b001);
        wr(OFS_FLAGS, 8'hFF); chk(flags, 8'hDF);
        wr(OFS_FLAGS, 8'h00); rdr(OFS_FLAGS); chk(rd, 8'h10);
        wr(2'h3, 8'hFF); rdr(2'h3); chk(rd, 8'h00);
        chk(flags, 8'h10);
    endtask : t_write
    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        #1 chk(flags, 8'h00);
        t_system();
        t_irq();
        t_alu();
        t_write();
        stop_test();
    end
endmodule : tb
